/* File: chan_regs_defs.vh */
// register addresses, widths, reset codes and gain law constants of the channel trim bank
// assumes the serial front end delivers a decoded address and one data byte
`ifndef CHAN_REGS_DEFS_VH
`define CHAN_REGS_DEFS_VH
`define ADDR_W 6
`define DATA_W 8
`define ADDR_OFFSET_RED 6'h20
`define ADDR_OFFSET_GREEN 6'h21
`define ADDR_OFFSET_BLUE 6'h22
`define ADDR_OFFSET_BCAST 6'h23
`define ADDR_GAIN_RED 6'h28
`define ADDR_GAIN_GREEN 6'h29
`define ADDR_GAIN_BLUE 6'h2A
`define ADDR_GAIN_BCAST 6'h2B
`define OFFSET_RESET 8'h80
`define GAIN_RESET 8'h00
`define GAIN_NUMER 9'h0D0
`define GAIN_DENOM_BASE 9'h11B
`endif

/* File: trim_reg.v */
// one 8-bit trim register with a single-channel and a broadcast load
// assumes both load strobes are one-cycle pulses on CLK_IN
`timescale 1ns/1ps
module trim_reg #(
	parameter WIDTH = 8,
	parameter [7:0] RESET_VAL = 8'h00
) (
	// clock and reset
	input wire clk_in,
	input wire arst_n_in,
	// load controls
	input wire own_wr_in,
	input wire bcast_wr_in,
	input wire [WIDTH-1:0] data_in,
	// stored code
	output reg [WIDTH-1:0] value_out
);
	// either a direct write or a broadcast write loads the value
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			value_out <= RESET_VAL[WIDTH-1:0];
		end else if (own_wr_in || bcast_wr_in) begin
			value_out <= data_in;
		end
	end
endmodule

/* File: channel_offset_gain_regs.v */
// per-colour offset trim and gain code register bank
// assumes a serial interface front end presents decoded write and read strobes
//
// Behaviour
// - red offset code is eight bits and resets to 80 hex
// - green offset code is eight bits and resets to 80 hex
// - blue offset code is eight bits and resets to 80 hex
// - broadcast offset write loads red, green and blue offset codes together
// - red gain code resets to zero; gain is 208 over 283 minus code
// - green gain code resets to zero; same gain law as red
// - blue gain code resets to zero; same gain law as red
// - broadcast gain write loads red, green and blue gain codes together
`timescale 1ns/1ps
`include "chan_regs_defs.vh"
module channel_offset_gain_regs #(
	parameter AW = `ADDR_W,
	parameter DW = `DATA_W
) (
	// clock and reset
	input wire CLK_IN,
	input wire ARST_N_IN,
	// register access from the serial interface
	input wire WR_EN_IN,
	input wire RD_EN_IN,
	input wire [AW-1:0] ADDR_IN,
	input wire [DW-1:0] WDATA_IN,
	output reg [DW-1:0] RDATA_OUT,
	output reg RVALID_OUT,
	output reg HIT_OUT,
	// codes to the analogue channels
	output wire [DW-1:0] OFFSET_TRIM_RED_OUT,
	output wire [DW-1:0] OFFSET_TRIM_GREEN_OUT,
	output wire [DW-1:0] OFFSET_TRIM_BLUE_OUT,
	output wire [DW-1:0] GAIN_CODE_RED_OUT,
	output wire [DW-1:0] GAIN_CODE_GREEN_OUT,
	output wire [DW-1:0] GAIN_CODE_BLUE_OUT,
	// gain law denominator per channel, gain = 208 / denom
	output reg [8:0] GAIN_DENOM_RED_OUT,
	output reg [8:0] GAIN_DENOM_GREEN_OUT,
	output reg [8:0] GAIN_DENOM_BLUE_OUT
);

	// stored codes from the trim registers
	wire [DW-1:0] offset_trim_red;
	wire [DW-1:0] offset_trim_green;
	wire [DW-1:0] offset_trim_blue;
	wire [DW-1:0] gain_code_red;
	wire [DW-1:0] gain_code_green;
	wire [DW-1:0] gain_code_blue;

	// decoded write strobes
	wire wr_off_r;
	wire wr_off_g;
	wire wr_off_b;
	wire wr_off_all;
	wire wr_gain_r;
	wire wr_gain_g;
	wire wr_gain_b;
	wire wr_gain_all;

	// read path next values
	reg [DW-1:0] nxt_rdata;
	reg nxt_hit;

	// address decode of write strobes, each selects one address; the two broadcast strobes each load three registers
	assign wr_off_r = WR_EN_IN && (ADDR_IN == `ADDR_OFFSET_RED);
	assign wr_off_g = WR_EN_IN && (ADDR_IN == `ADDR_OFFSET_GREEN);
	assign wr_off_b = WR_EN_IN && (ADDR_IN == `ADDR_OFFSET_BLUE);
	assign wr_off_all = WR_EN_IN && (ADDR_IN == `ADDR_OFFSET_BCAST);
	assign wr_gain_r = WR_EN_IN && (ADDR_IN == `ADDR_GAIN_RED);
	assign wr_gain_g = WR_EN_IN && (ADDR_IN == `ADDR_GAIN_GREEN);
	assign wr_gain_b = WR_EN_IN && (ADDR_IN == `ADDR_GAIN_BLUE);
	assign wr_gain_all = WR_EN_IN && (ADDR_IN == `ADDR_GAIN_BCAST);

	// offset trim registers, broadcast strobe shared by all three
	// red offset code
	trim_reg #(
		.WIDTH(DW),
		.RESET_VAL(`OFFSET_RESET)
	) u_off_r (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.own_wr_in(wr_off_r),
		.bcast_wr_in(wr_off_all),
		.data_in(WDATA_IN),
		.value_out(offset_trim_red)
	);

	// green offset code
	trim_reg #(
		.WIDTH(DW),
		.RESET_VAL(`OFFSET_RESET)
	) u_off_g (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.own_wr_in(wr_off_g),
		.bcast_wr_in(wr_off_all),
		.data_in(WDATA_IN),
		.value_out(offset_trim_green)
	);

	// blue offset code
	trim_reg #(
		.WIDTH(DW),
		.RESET_VAL(`OFFSET_RESET)
	) u_off_b (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.own_wr_in(wr_off_b),
		.bcast_wr_in(wr_off_all),
		.data_in(WDATA_IN),
		.value_out(offset_trim_blue)
	);

	// gain code registers, broadcast strobe shared by all three
	// red gain code
	trim_reg #(
		.WIDTH(DW),
		.RESET_VAL(`GAIN_RESET)
	) u_gain_r (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.own_wr_in(wr_gain_r),
		.bcast_wr_in(wr_gain_all),
		.data_in(WDATA_IN),
		.value_out(gain_code_red)
	);

	// green gain code
	trim_reg #(
		.WIDTH(DW),
		.RESET_VAL(`GAIN_RESET)
	) u_gain_g (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.own_wr_in(wr_gain_g),
		.bcast_wr_in(wr_gain_all),
		.data_in(WDATA_IN),
		.value_out(gain_code_green)
	);

	// blue gain code
	trim_reg #(
		.WIDTH(DW),
		.RESET_VAL(`GAIN_RESET)
	) u_gain_b (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.own_wr_in(wr_gain_b),
		.bcast_wr_in(wr_gain_all),
		.data_in(WDATA_IN),
		.value_out(gain_code_blue)
	);

	// codes straight from the register flops
	assign OFFSET_TRIM_RED_OUT = offset_trim_red;
	assign OFFSET_TRIM_GREEN_OUT = offset_trim_green;
	assign OFFSET_TRIM_BLUE_OUT = offset_trim_blue;
	assign GAIN_CODE_RED_OUT = gain_code_red;
	assign GAIN_CODE_GREEN_OUT = gain_code_green;
	assign GAIN_CODE_BLUE_OUT = gain_code_blue;

	// red gain law denominator 283 minus code, one cycle behind the code
	always @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			GAIN_DENOM_RED_OUT <= `GAIN_DENOM_BASE;
		end else begin
			GAIN_DENOM_RED_OUT <= `GAIN_DENOM_BASE - {1'b0, gain_code_red};
		end
	end

	// green gain law denominator, same timing as red
	always @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			GAIN_DENOM_GREEN_OUT <= `GAIN_DENOM_BASE;
		end else begin
			GAIN_DENOM_GREEN_OUT <= `GAIN_DENOM_BASE - {1'b0, gain_code_green};
		end
	end

	// blue gain law denominator, same timing as red
	always @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			GAIN_DENOM_BLUE_OUT <= `GAIN_DENOM_BASE;
		end else begin
			GAIN_DENOM_BLUE_OUT <= `GAIN_DENOM_BASE - {1'b0, gain_code_blue};
		end
	end

	// read mux, broadcast locations are write only and read zero
	always @* begin
		nxt_rdata = 8'h00;
		nxt_hit = 1'b1;
		case (ADDR_IN)
			`ADDR_OFFSET_RED: nxt_rdata = offset_trim_red;
			`ADDR_OFFSET_GREEN: nxt_rdata = offset_trim_green;
			`ADDR_OFFSET_BLUE: nxt_rdata = offset_trim_blue;
			`ADDR_GAIN_RED: nxt_rdata = gain_code_red;
			`ADDR_GAIN_GREEN: nxt_rdata = gain_code_green;
			`ADDR_GAIN_BLUE: nxt_rdata = gain_code_blue;
			`ADDR_OFFSET_BCAST: nxt_hit = 1'b1;
			`ADDR_GAIN_BCAST: nxt_hit = 1'b1;
			default: nxt_hit = 1'b0;
		endcase
	end

	// read data register, one cycle after the read strobe
	always @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			RDATA_OUT <= 8'h00;
			RVALID_OUT <= 1'b0;
			HIT_OUT <= 1'b0;
		end else begin
			RVALID_OUT <= RD_EN_IN;
			if (RD_EN_IN) begin
				RDATA_OUT <= nxt_rdata;
				HIT_OUT <= nxt_hit;
			end
		end
	end
endmodule

/* File: host_model.sv */
// host controller model issuing single register writes and reads
// assumes the bank takes a request at the rising clock edge
`timescale 1ns/1ps
module host_model (
	input wire clk_in,
	output reg wr_en_out = 0,
	output reg rd_en_out = 0,
	output reg [5:0] addr_out = 0,
	output reg [7:0] wdata_out = 0
);
	// one request per call, lines scrambled once released
	task xfer(input w, input [5:0] a, input [7:0] d);
		begin
			@(posedge clk_in) #1;
			{wr_en_out, rd_en_out, addr_out, wdata_out} = {w, !w, a, d};
			@(posedge clk_in) #1;
			{wr_en_out, rd_en_out, addr_out, wdata_out} = {2'b00, ~a, ~d};
		end
	endtask
endmodule

/* File: cogr_asserts.sv */
// timing checks on the trim and gain bank ports
// assumes default widths of six address and eight data bits
`timescale 1ns/1ps
module cogr_asserts (
	input wire CLK_IN, ARST_N_IN, WR_EN_IN, RD_EN_IN, RVALID_OUT, HIT_OUT,
	input wire [5:0] ADDR_IN,
	input wire [7:0] WDATA_IN, RDATA_OUT, OFFSET_TRIM_RED_OUT, OFFSET_TRIM_GREEN_OUT, OFFSET_TRIM_BLUE_OUT,
	input wire [7:0] GAIN_CODE_RED_OUT, GAIN_CODE_GREEN_OUT, GAIN_CODE_BLUE_OUT,
	input wire [8:0] GAIN_DENOM_RED_OUT, GAIN_DENOM_GREEN_OUT, GAIN_DENOM_BLUE_OUT
);
	// channel codes gathered red first
	wire [23:0] ofs = {OFFSET_TRIM_RED_OUT, OFFSET_TRIM_GREEN_OUT, OFFSET_TRIM_BLUE_OUT};
	wire [23:0] gn = {GAIN_CODE_RED_OUT, GAIN_CODE_GREEN_OUT, GAIN_CODE_BLUE_OUT};
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	AST_RST_CODES: assert property ($rose(ARST_N_IN) |-> ofs == 24'h808080 && gn == 24'h000000)
		else $error("codes not at reset values");
	AST_OFS_BCAST: assert property (WR_EN_IN && ADDR_IN == 6'h23 |=> ofs == {3{$past(WDATA_IN)}})
		else $error("offset broadcast missed");
	AST_GAIN_BCAST: assert property (WR_EN_IN && ADDR_IN == 6'h2B |=> gn == {3{$past(WDATA_IN)}})
		else $error("gain broadcast missed");
	AST_OFS_RED: assert property (WR_EN_IN && ADDR_IN == 6'h20 |=> ofs == {$past(WDATA_IN), $past(ofs[15:0])})
		else $error("red offset write wrong");
	AST_GAIN_GREEN: assert property (WR_EN_IN && ADDR_IN == 6'h29 |=> gn == {$past(gn[23:16]), $past(WDATA_IN), $past(gn[7:0])})
		else $error("green gain write wrong");
	AST_HOLD: assert property (!WR_EN_IN |=> $stable(ofs) && $stable(gn))
		else $error("code moved without write");
	AST_DENOM: assert property (1 |=> GAIN_DENOM_RED_OUT == 9'h11B - $past(gn[23:16]) && GAIN_DENOM_GREEN_OUT == 9'h11B - $past(gn[15:8]) && GAIN_DENOM_BLUE_OUT == 9'h11B - $past(gn[7:0]))
		else $error("gain denominator wrong");
	AST_RD_GAIN: assert property (RD_EN_IN && ADDR_IN == 6'h28 |=> RVALID_OUT && HIT_OUT && RDATA_OUT == $past(gn[23:16]))
		else $error("red gain read wrong");
	AST_RD_BCAST: assert property (RD_EN_IN && ADDR_IN == 6'h23 |=> RVALID_OUT && HIT_OUT && RDATA_OUT == 8'h00)
		else $error("broadcast read wrong");
endmodule
bind channel_offset_gain_regs cogr_asserts i_cogr_asserts (.*);

/* File: channel_offset_gain_regs_test.sv */
// random register traffic against a bench model of the trim bank
// assumes the host model and the bound checker
`timescale 1ns/1ps
module channel_offset_gain_regs_test;
	reg clk = 0, arst_n = 0, w;
	wire wr, rd, rvalid, hit;
	wire [5:0] addr;
	wire [7:0] wdata, rdata;
	wire [7:0] code [0:5];
	wire [8:0] den [0:2];
	integer fail_count = 0, checks = 0, cyc = 0, i, k;
	reg [7:0] m [0:7];
	reg [5:0] a;
	reg [7:0] d;
	host_model i_host_model (.clk_in(clk), .wr_en_out(wr), .rd_en_out(rd), .addr_out(addr), .wdata_out(wdata));
	channel_offset_gain_regs i_channel_offset_gain_regs (.CLK_IN(clk), .ARST_N_IN(arst_n), .WR_EN_IN(wr),
		.RD_EN_IN(rd), .ADDR_IN(addr), .WDATA_IN(wdata), .RDATA_OUT(rdata), .RVALID_OUT(rvalid), .HIT_OUT(hit),
		.OFFSET_TRIM_RED_OUT(code[0]), .OFFSET_TRIM_GREEN_OUT(code[1]), .OFFSET_TRIM_BLUE_OUT(code[2]),
		.GAIN_CODE_RED_OUT(code[3]), .GAIN_CODE_GREEN_OUT(code[4]), .GAIN_CODE_BLUE_OUT(code[5]),
		.GAIN_DENOM_RED_OUT(den[0]), .GAIN_DENOM_GREEN_OUT(den[1]), .GAIN_DENOM_BLUE_OUT(den[2]));
	function hitx(input [5:0] a);
		hitx = a[5:4] == 2'b10 && !a[2];
	endfunction
	function [7:0] exp_rd(input [5:0] a);
		exp_rd = hitx(a) && a[1:0] != 2'b11 ? m[{a[3], a[1:0]}] : 8'h00;
	endfunction
	// bench model update on a write
	task upd(input [5:0] a, input [7:0] d);
		begin
			if (hitx(a) && a[1:0] == 2'b11) {m[a[3] * 4], m[a[3] * 4 + 1], m[a[3] * 4 + 2]} = {3{d}};
			else if (hitx(a)) m[{a[3], a[1:0]}] = d;
		end
	endtask
	task chk(input [39:0] n, input [8:0] e, input [8:0] s);
		begin
			checks = checks + 1;
			if (s !== e) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED %s exp %h got %h", n, e, s);
			end
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d fail_count %0d", checks, fail_count);
			if (fail_count == 0 && checks > 0) $display("TEST PASSED");
			else $display("TEST FAILED");
			$finish;
		end
	endtask
	initial forever #5 clk = ~clk;
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count = fail_count + 1;
			stop_test;
		end
	end
	// reads of addresses 20 to 2F hex first, then random traffic
	initial begin
		d = 8'($urandom(32'hD1DE3AAB));
		for (i = 0; i < 8; i = i + 1) m[i] = i < 4 ? 8'h80 : 8'h00;
		repeat (8) @(posedge clk);
		#1 arst_n = 1;
		for (i = 0; i < 400; i = i + 1) begin
			// mid-run reset must bring every code back to its reset value
			if (i == 200) begin
				arst_n = 0;
				for (k = 0; k < 8; k = k + 1) m[k] = k < 4 ? 8'h80 : 8'h00;
				@(posedge clk) #1 arst_n = 1;
			end
			w = i > 15 && $urandom % 2;
			a = i < 16 ? 6'(6'h20 + i) : {2'b10, 4'($urandom)};
			d = 8'($urandom);
			if (i == 16 || i == 17) {w, a, d} = {1'b1, i == 16 ? 6'h2B : 6'h23, 8'hFF};
			i_host_model.xfer(w, a, d);
			if (w) upd(a, d);
			else chk("rdata", {1'b0, exp_rd(a)}, {1'b0, rdata});
			if (!w) chk("hit", {7'h00, 1'b1, hitx(a)}, {7'h00, rvalid, hit});
			if (w) chk("rvld", 9'h000, {8'h00, rvalid});
			for (k = 0; k < 6; k = k + 1) chk("code", {1'b0, m[k + k / 3]}, {1'b0, code[k]});
			@(posedge clk) #1;
			for (k = 0; k < 3; k = k + 1) chk("den", 9'h11B - m[k + 4], den[k]);
			chk("rvld", 9'h000, {8'h00, rvalid});
			if (!w) chk("rhold", {1'b0, exp_rd(a)}, {1'b0, rdata});
		end
		stop_test;
	end
endmodule
